// ---- include/trace_pkg.sv ----
// constants, types and helpers for the bus cycle trace recorder
package trace_pkg;

    // clock and time stamp rates
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned STAMP_NS_0    = 125;
    localparam int unsigned STAMP_NS_1    = 250;
    localparam int unsigned STAMP_NS_2    = 500;
    localparam int unsigned STAMP_NS_3    = 1000;
    localparam int unsigned STAMP_NS_4    = 2000;
    localparam int unsigned STAMP_NS_5    = 4000;
    localparam int unsigned STAMP_NS_6    = 8000;
    localparam int unsigned STAMP_NS_7    = 16000;
    localparam int unsigned STAMP_NS_8    = 100000;
    localparam int unsigned NS_PER_US     = 1000;
    localparam int          DIV_W         = 16;

    // record geometry
    localparam int          ADDR_W        = 24;
    localparam int          DATA_W        = 16;
    localparam int          STAMP_W       = 32;
    localparam int          PROBE_W       = 4;
    localparam int          IRQ_W         = 8;
    localparam int          TICK_W        = 4;
    localparam logic [3:0]  CLK_COUNT_MAX = 4'h8;
    localparam logic [3:0]  TICK_SAT      = 4'h9;
    localparam int          TRACE_DEPTH   = 32768;
    localparam int          FIFO_DEPTH    = 16;

    // register offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_DELAY     = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    localparam logic [7:0]  OFS_INDEX     = 8'h0c;
    localparam logic [7:0]  OFS_REC_ADDR  = 8'h10;
    localparam logic [7:0]  OFS_REC_DATA  = 8'h14;
    localparam logic [7:0]  OFS_REC_INFO  = 8'h18;
    localparam logic [7:0]  OFS_COUNT     = 8'h1c;
    localparam int          REG_ADDR_W    = 8;

    // field positions
    localparam int          CTRL_RATE_LSB = 0;
    localparam int          CTRL_RATE_W   = 4;
    localparam int          CTRL_DELAY_EN = 8;
    localparam int          REC_WRITE_BIT = 24;
    localparam int          REC_BYTE_BIT  = 25;
    localparam logic [3:0]  RATE_OFF      = 4'h0;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        AREA_ROM      = 3'h0,
        AREA_RAM      = 3'h1,
        AREA_IO8      = 3'h2,
        AREA_IO16     = 3'h3,
        AREA_EXT8     = 3'h4,
        AREA_EXT16    = 3'h5,
        AREA_XFER_RAM = 3'h6
    } area_e;

    typedef enum logic [2:0] {
        STAT_TRANSFER_CONTROLLER = 3'h0,
        STAT_PREFETCH            = 3'h1,
        STAT_CPU_DATA            = 3'h2,
        STAT_REFRESH             = 3'h3,
        STAT_DMA                 = 3'h4
    } bus_status_e;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RUN   = 4'h2,
        ST_DELAY = 4'h4,
        ST_DONE  = 4'h8
    } cap_state_e;

    // one completed target bus cycle as seen on the pins
    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
        logic               is_byte;
        logic               is_write;
        area_e              area;
        bus_status_e        status;
        logic [PROBE_W-1:0] probes;
        logic               nmi_level;
        logic [IRQ_W-1:0]   interrupt_request_levels;
    } bus_cycle_s;

    // stored record; info holds details or the time stamp
    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
        logic               is_byte;
        logic               is_write;
        logic               stop_mark;
        logic [STAMP_W-1:0] info;
    } record_s;

    function automatic logic [DIV_W-1:0] stamp_div(input logic [3:0] sel);
        case (sel)
            4'h1: stamp_div = DIV_W'(STAMP_NS_0 * CLK_MHZ / NS_PER_US);
            4'h2: stamp_div = DIV_W'(STAMP_NS_1 * CLK_MHZ / NS_PER_US);
            4'h3: stamp_div = DIV_W'(STAMP_NS_2 * CLK_MHZ / NS_PER_US);
            4'h4: stamp_div = DIV_W'(STAMP_NS_3 * CLK_MHZ / NS_PER_US);
            4'h5: stamp_div = DIV_W'(STAMP_NS_4 * CLK_MHZ / NS_PER_US);
            4'h6: stamp_div = DIV_W'(STAMP_NS_5 * CLK_MHZ / NS_PER_US);
            4'h7: stamp_div = DIV_W'(STAMP_NS_6 * CLK_MHZ / NS_PER_US);
            4'h8: stamp_div = DIV_W'(STAMP_NS_7 * CLK_MHZ / NS_PER_US);
            4'h9: stamp_div = DIV_W'(STAMP_NS_8 * CLK_MHZ / NS_PER_US);
            default: stamp_div = '0;
        endcase
    endfunction

endpackage

// ---- hdl/bus_cycle_trace_recorder.sv ----
// bus cycle trace recorder with record fifo and ahb-lite readout
//
// Notes on behaviour
// - with no stop set up, every completed bus cycle is captured
// - capture starts at program start and ends at program halt
// - newest record is index 0, older ones -1, -2 and onward
// - with a delay, the stop record is index 0, later ones +1, +2
// - each record keeps the 24-bit bus address
// - each record keeps the data, a byte or a 16-bit word
// - each record keeps a read or write flag
// - each record keeps the accessed area code
// - each record keeps the bus status code
// - clock count 1 to 8 per cycle, above 8 sets saturation flag
// - four probe pins stored, probe 4 in the top bit
// - nmi level and eight interrupt request levels stored
// - time stamp restarts at program start, ticks at chosen rate
// - with time stamps, detail fields give way to the stamp
// - store holds up to 32768 records of the latest run
// - when full, a new record overwrites the oldest one
// - 32-bit stamp counter wraps to zero and keeps counting
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps

module trace_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_state_s;

    fifo_state_s s;
    fifo_state_s next_s;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    assign in_ready  = s.cnt != (AW+1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data  = mem[s.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wp = s.wp + AW'(1);
        end
        if (pop) begin
            next_s.rp = s.rp + AW'(1);
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wp] <= in_data;
        end
    end
endmodule

module bus_cycle_trace_recorder #(
    parameter int DEPTH      = trace_pkg::TRACE_DEPTH,
    parameter int FIFO_DEPTH = trace_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // ahb-lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // target processor bus
    input  wire logic                       prefetch_cycle_status_running,
    input  wire logic                       clock_tick,
    input  wire logic                       cycle_done,
    input  wire trace_pkg::bus_cycle_s      target,
    input  wire logic                       stop_event,
    // status
    output logic                            capture_active
);
    localparam int AW = $clog2(DEPTH);
    localparam int RW = $bits(trace_pkg::record_s);

    typedef struct packed {
        trace_pkg::cap_state_e              st;
        logic                               prefetch_cycle_status_prev;
        logic [trace_pkg::CTRL_RATE_W-1:0]  rate_sel;
        logic                               delay_en;
        logic [15:0]                        delay_cnt;
        logic [15:0]                        delay_left;
        logic [trace_pkg::TICK_W-1:0]       ticks;
        logic [trace_pkg::DIV_W-1:0]        presc;
        logic [trace_pkg::STAMP_W-1:0]      stamp;
        logic [AW-1:0]                      wptr;
        logic [AW:0]                        fill;
        logic [AW-1:0]                      ref_ptr;
        logic                               ref_valid;
        logic                               lost;
        logic [31:0]                        index;
        logic                               fetch_pend;
        logic                               fetch_load;
        trace_pkg::record_s                 rec;
        logic                               ap_write;
        logic [trace_pkg::REG_ADDR_W-1:0]   ap_addr;
        logic [31:0]                        hrdata;
        logic                               hreadyout;
        logic                               capture_active;
    } top_state_s;

    top_state_s          s;
    top_state_s          next_s;
    trace_pkg::record_s  mem [DEPTH];
    trace_pkg::record_s  rd_q;
    trace_pkg::record_s  cap_rec;
    trace_pkg::record_s  drain_rec;
    logic                cap_valid;
    logic                cap_ready;
    logic                drain_valid;
    logic                drain_ready;
    logic                drain_fire;
    logic [AW-1:0]       fetch_ptr;
    logic [3:0]          cycle_ticks;
    logic [trace_pkg::DIV_W-1:0] div;

    function automatic logic [31:0] read_reg(
        input top_state_s                     st,
        input logic [trace_pkg::REG_ADDR_W-1:0] a
    );
        logic [31:0] v;
        v = '0;
        case (a)
            trace_pkg::OFS_CTRL: begin
                v[trace_pkg::CTRL_RATE_LSB +: trace_pkg::CTRL_RATE_W] =
                    st.rate_sel;
                v[trace_pkg::CTRL_DELAY_EN] = st.delay_en;
            end
            trace_pkg::OFS_DELAY:    v[15:0] = st.delay_cnt;
            trace_pkg::OFS_STATUS: begin
                v[3:0] = st.st;
                v[4]   = st.ref_valid;
                v[5]   = st.lost;
                v[6]   = st.fetch_pend | st.fetch_load;
            end
            trace_pkg::OFS_INDEX:    v = st.index;
            trace_pkg::OFS_REC_ADDR: begin
                v[trace_pkg::ADDR_W-1:0]     = st.rec.addr;
                v[trace_pkg::REC_WRITE_BIT] = st.rec.is_write;
                v[trace_pkg::REC_BYTE_BIT]  = st.rec.is_byte;
            end
            trace_pkg::OFS_REC_DATA: v[15:0] = st.rec.data;
            trace_pkg::OFS_REC_INFO: v = st.rec.info;
            trace_pkg::OFS_COUNT:    v[AW:0] = st.fill;
            default:                 v = '0;
        endcase
        return v;
    endfunction

    // record fifo between capture and the trace store
    trace_fifo #(
        .W     (RW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (cap_rec),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_rec)
    );

    // readout fetch has the store port; draining waits meanwhile
    assign drain_ready = !s.fetch_pend;
    assign drain_fire  = drain_valid && drain_ready;
    // index 0 is the stop record if one was marked, else the newest
    assign fetch_ptr   = (s.ref_valid ? s.ref_ptr : s.wptr - AW'(1))
                         + s.index[AW-1:0];
    assign div         = trace_pkg::stamp_div(s.rate_sel);
    assign cycle_ticks = (clock_tick && s.ticks != trace_pkg::TICK_SAT)
                         ? s.ticks + 4'h1 : s.ticks;

    // record building from the completed bus cycle
    always_comb begin
        cap_rec          = '0;
        cap_rec.addr     = target.addr;
        cap_rec.is_byte  = target.is_byte;
        cap_rec.data     = target.is_byte
                           ? {8'h00, target.data[7:0]} : target.data;
        cap_rec.is_write = target.is_write;
        cap_rec.stop_mark = (s.st == trace_pkg::ST_RUN) && stop_event;
        if (s.rate_sel != trace_pkg::RATE_OFF && div != '0) begin
            cap_rec.info = s.stamp;
        end else begin
            cap_rec.info[23:21] = target.area;
            cap_rec.info[20:18] = target.status;
            cap_rec.info[17:14] =
                (cycle_ticks > trace_pkg::CLK_COUNT_MAX)
                ? trace_pkg::CLK_COUNT_MAX : cycle_ticks;
            cap_rec.info[13] =
                cycle_ticks > trace_pkg::CLK_COUNT_MAX;
            cap_rec.info[12:9] = target.probes;
            cap_rec.info[8]    = target.nmi_level;
            cap_rec.info[7:0]  = target.interrupt_request_levels;
        end
        cap_valid = cycle_done && (s.st == trace_pkg::ST_RUN
                    || s.st == trace_pkg::ST_DELAY);
    end

    always_comb begin
        next_s = s;
        next_s.prefetch_cycle_status_prev = prefetch_cycle_status_running;

        // clock counting within the current bus cycle
        next_s.ticks = cycle_done ? '0 : cycle_ticks;

        // time stamp prescaler and counter
        if (div != '0) begin
            if (s.presc >= div - trace_pkg::DIV_W'(1)) begin
                next_s.presc = '0;
                next_s.stamp = s.stamp + 32'h1;
            end else begin
                next_s.presc = s.presc + trace_pkg::DIV_W'(1);
            end
        end

        // capture sequence
        case (s.st)
            trace_pkg::ST_IDLE: begin
                if (prefetch_cycle_status_running && !s.prefetch_cycle_status_prev) begin
                    next_s.st        = trace_pkg::ST_RUN;
                    next_s.stamp     = '0;
                    next_s.presc     = '0;
                    next_s.ticks     = '0;
                    next_s.lost      = 1'b0;
                    next_s.ref_valid = 1'b0;
                    next_s.wptr      = '0;
                    next_s.fill      = '0;
                end
            end
            trace_pkg::ST_RUN: begin
                if (cap_valid && stop_event) begin
                    if (s.delay_en && s.delay_cnt != '0) begin
                        next_s.st         = trace_pkg::ST_DELAY;
                        next_s.delay_left = s.delay_cnt;
                    end else begin
                        next_s.st = trace_pkg::ST_DONE;
                    end
                end
            end
            trace_pkg::ST_DELAY: begin
                if (cap_valid) begin
                    next_s.delay_left = s.delay_left - 16'h1;
                    if (s.delay_left == 16'h1) begin
                        next_s.st = trace_pkg::ST_DONE;
                    end
                end
            end
            trace_pkg::ST_DONE: begin
                next_s.st = s.st;
            end
            default: begin
                next_s.st = trace_pkg::ST_IDLE;
            end
        endcase
        if (!prefetch_cycle_status_running && s.st != trace_pkg::ST_IDLE) begin
            next_s.st = trace_pkg::ST_IDLE;
        end
        if (cap_valid && !cap_ready) begin
            next_s.lost = 1'b1;
        end
        next_s.capture_active = next_s.st == trace_pkg::ST_RUN
                                || next_s.st == trace_pkg::ST_DELAY;

        // draining into the circular store
        if (drain_fire) begin
            next_s.wptr = s.wptr + AW'(1);
            if (s.fill != (AW+1)'(DEPTH)) begin
                next_s.fill = s.fill + (AW+1)'(1);
            end
            if (drain_rec.stop_mark) begin
                next_s.ref_ptr   = s.wptr;
                next_s.ref_valid = 1'b1;
            end
        end

        // record fetch for readout
        next_s.fetch_load = s.fetch_pend;
        next_s.fetch_pend = 1'b0;
        if (s.fetch_load) begin
            next_s.rec = rd_q;
        end

        // ahb-lite data phase write
        if (s.ap_write) begin
            case (s.ap_addr)
                trace_pkg::OFS_CTRL: begin
                    next_s.rate_sel = hwdata[trace_pkg::CTRL_RATE_LSB +:
                                             trace_pkg::CTRL_RATE_W];
                    next_s.delay_en = hwdata[trace_pkg::CTRL_DELAY_EN];
                end
                trace_pkg::OFS_DELAY: next_s.delay_cnt = hwdata[15:0];
                trace_pkg::OFS_INDEX: begin
                    next_s.index      = hwdata;
                    next_s.fetch_pend = 1'b1;
                end
                default: next_s.index = s.index;
            endcase
        end

        // ahb-lite address phase
        next_s.ap_write  = 1'b0;
        next_s.hreadyout = 1'b1;
        if (hsel && hready && htrans == trace_pkg::HTRANS_NONSEQ) begin
            next_s.ap_write = hwrite;
            next_s.ap_addr  = haddr[trace_pkg::REG_ADDR_W-1:0];
            next_s.hrdata   = hwrite ? 32'h0
                              : read_reg(s, haddr[trace_pkg::REG_ADDR_W-1:0]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s           <= '0;
            s.st        <= trace_pkg::ST_IDLE;
            s.hreadyout <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // trace store, one port shared by drain and fetch
    always_ff @(posedge clk) begin
        if (drain_fire) begin
            mem[s.wptr] <= drain_rec;
        end
        if (s.fetch_pend) begin
            rd_q <= mem[fetch_ptr];
        end
    end

    assign hreadyout      = s.hreadyout;
    assign hresp          = 1'b0;
    assign hrdata         = s.hrdata;
    assign capture_active = s.capture_active;
endmodule

// ---- bench/bus_cycle_trace_recorder_assertions.sv ----
// checker for the recorder register bus and capture status
`timescale 1ns/10ps
module trace_recorder_checker #(
    parameter int DEPTH = trace_pkg::TRACE_DEPTH
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // ahb-lite slave
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // capture
    input wire logic        prefetch_cycle_status_running,
    input wire logic        capture_active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    wire logic       rd_req = hsel && hready && htrans == 2'h2 && !hwrite;
    wire logic [7:0] ofs    = haddr[7:0];

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_zero_wait: assert property ($past(arst_n) |-> hreadyout)
        else $error("wait state inserted");
    chk_unmapped_zero: assert property (
        rd_req && ofs > 8'h1c |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_status_onehot: assert property (
        rd_req && ofs == trace_pkg::OFS_STATUS
        |=> $onehot(hrdata[3:0]) && hrdata[31:7] == 25'h0)
        else $error("status state not one-hot");
    chk_count_bound: assert property (
        rd_req && ofs == trace_pkg::OFS_COUNT |=> hrdata <= DEPTH)
        else $error("record count above depth");
    chk_addr_width: assert property (
        rd_req && ofs == trace_pkg::OFS_REC_ADDR |=> hrdata[31:26] == 6'h0)
        else $error("record address word too wide");
    chk_data_width: assert property (
        rd_req && ofs == trace_pkg::OFS_REC_DATA |=> hrdata[31:16] == 16'h0)
        else $error("record data word too wide");
    chk_start_capture: assert property (
        $rose(prefetch_cycle_status_running) |-> ##[0:2] capture_active)
        else $error("capture did not start");
    chk_halt_capture: assert property (
        !prefetch_cycle_status_running [*3] |-> !capture_active)
        else $error("capture active while halted");
endmodule

bind bus_cycle_trace_recorder trace_recorder_checker #(.DEPTH(DEPTH))
    i_trace_recorder_checker (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .prefetch_cycle_status_running(prefetch_cycle_status_running), .capture_active(capture_active));

// ---- bench/target_bus_model.sv ----
// target processor bus model issuing completed bus cycles
`timescale 1ns/10ps
module target_bus_model (
    // clock
    input  wire logic             clk,
    // target bus
    output logic                  prefetch_cycle_status_running,
    output logic                  clock_tick,
    output logic                  cycle_done,
    output logic                  stop_event,
    output trace_pkg::bus_cycle_s target
);
    initial begin
        prefetch_cycle_status_running = 1'b0;
        {clock_tick, cycle_done, stop_event} = 3'h0;
        target = '0;
    end

    task automatic run(input logic v);
        prefetch_cycle_status_running <= v;
        repeat (4) @(posedge clk);
    endtask

    // n target clocks; fields valid only with the done pulse
    task automatic cyc(input trace_pkg::bus_cycle_s c, input int n,
                       input logic stp);
        clock_tick <= 1'b1;
        if (n > 1) begin
            target <= ~c;
            repeat (n - 1) @(posedge clk);
        end
        cycle_done <= 1'b1;
        stop_event <= stp;
        target <= c;
        @(posedge clk);
        {clock_tick, cycle_done, stop_event} <= 3'h0;
        target <= ~c;
        @(posedge clk);
    endtask
endmodule

// ---- bench/tb_bus_cycle_trace_recorder.sv ----
// testbench for the bus cycle trace recorder
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_bus_cycle_trace_recorder;
    localparam int DEPTH = 16;
    logic                  clk;
    logic                  arst_n;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [31:0]           hwdata;
    logic                  hreadyout;
    logic                  hresp;
    logic [31:0]           hrdata;
    logic                  prefetch_cycle_status_running;
    logic                  clock_tick;
    logic                  cycle_done;
    logic                  stop_event;
    logic                  capture_active;
    trace_pkg::bus_cycle_s target;
    logic [31:0]           rdat;
    int                    errors;
    int                    total_checks;

    bus_cycle_trace_recorder #(.DEPTH(DEPTH))
        i_bus_cycle_trace_recorder (
        .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .prefetch_cycle_status_running(prefetch_cycle_status_running),
        .clock_tick(clock_tick), .cycle_done(cycle_done), .target(target),
        .stop_event(stop_event), .capture_active(capture_active));
    target_bus_model i_target_bus_model (
        .clk(clk), .prefetch_cycle_status_running(prefetch_cycle_status_running), .clock_tick(clock_tick),
        .cycle_done(cycle_done), .stop_event(stop_event), .target(target));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        rdat = hrdata;
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h0);
    endtask

    function automatic trace_pkg::bus_cycle_s mk(input logic [7:0] i);
        mk.addr = {16'hab00, i};
        mk.data = {i, ~i};
        mk.is_byte = i[0];
        mk.is_write = i[1];
        mk.area = trace_pkg::area_e'(3'(i % 7));
        mk.status = trace_pkg::bus_status_e'(3'(i % 5));
        mk.probes = i[3:0];
        mk.nmi_level = i[4];
        mk.interrupt_request_levels = ~i;
    endfunction

    // n > 0 clock count, n < 0 expected stamp -n-1, n == 0 no info
    task automatic chk_rec(input logic [31:0] idx, input logic [7:0] i,
                           input int n);
        trace_pkg::bus_cycle_s c;
        c = mk(i);
        xfer(trace_pkg::OFS_INDEX, 1'b1, idx);
        repeat (3) @(posedge clk);
        rd(trace_pkg::OFS_REC_ADDR);
        `CHK(rdat, {6'h0, c.is_byte, c.is_write, c.addr})
        rd(trace_pkg::OFS_REC_DATA);
        `CHK(rdat[15:0], {c.is_byte ? 8'h0 : c.data[15:8], c.data[7:0]})
        rd(trace_pkg::OFS_REC_INFO);
        if (n > 8)
            `CHK(rdat[13], 1'b1)
        else if (n > 0)
            `CHK(rdat, {8'h0, c.area, c.status, 4'(n), 1'b0, c.probes,
                c.nmi_level, c.interrupt_request_levels})
        else if (n < 0)
            `CHK(rdat, 32'(-n - 1))
    endtask

    task automatic end_sim;
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        end_sim;
    end

    initial begin
        {arst_n, hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
        errors = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(8'h40);
        `CHK(rdat, 32'h0)
        // overfill the store
        i_target_bus_model.run(1'b1);
        for (int k = 0; k < 20; k++)
            i_target_bus_model.cyc(mk(8'(k)), 1, 1'b0);
        i_target_bus_model.run(1'b0);
        rd(trace_pkg::OFS_COUNT);
        `CHK(rdat, 32'(DEPTH))
        chk_rec(32'(1 - DEPTH), 8'h4, 0);
        chk_rec(32'h0, 8'h13, 0);
        // all fields, clock counts 1 to 9
        i_target_bus_model.run(1'b1);
        for (int k = 0; k < 9; k++)
            i_target_bus_model.cyc(mk(8'(k)), k + 1, 1'b0);
        i_target_bus_model.run(1'b0);
        i_target_bus_model.cyc(mk(8'h55), 1, 1'b0);
        rd(trace_pkg::OFS_COUNT);
        `CHK(rdat, 32'h9)
        for (int k = 0; k < 9; k++) chk_rec(32'(-k), 8'(8 - k), 9 - k);
        // delayed stop
        xfer(trace_pkg::OFS_CTRL, 1'b1, 32'h100);
        xfer(trace_pkg::OFS_DELAY, 1'b1, 32'h2);
        i_target_bus_model.run(1'b1);
        for (int k = 0; k < 7; k++)
            i_target_bus_model.cyc(mk(8'(k)), 1, k == 3);
        `CHK(capture_active, 1'b0)
        i_target_bus_model.run(1'b0);
        rd(trace_pkg::OFS_COUNT);
        `CHK(rdat, 32'h6)
        for (int k = -1; k < 3; k++) chk_rec(32'(k), 8'(k + 3), 0);
        // time stamps at six clocks a tick
        xfer(trace_pkg::OFS_CTRL, 1'b1, 32'h1);
        repeat (2) begin
            i_target_bus_model.run(1'b1);
            i_target_bus_model.cyc(mk(8'h0), 1, 1'b0);
            i_target_bus_model.cyc(mk(8'h1), 59, 1'b0);
            i_target_bus_model.run(1'b0);
            chk_rec(32'hffffffff, 8'h0, -1);
            chk_rec(32'h0, 8'h1, -11);
        end
        rd(trace_pkg::OFS_STATUS);
        `CHK(rdat, 32'h1)
        end_sim;
    end
endmodule
